// ==== ofd_pkg.sv ====
/*
 Constants, formats and carrier structs for the operand field decoder.
 Assumes a core that classifies each fetched word into an ofd_fmt_t.
*/
package ofd_pkg;
  // Instruction format classes supplied by the opcode decoder
  typedef enum logic [3:0] {
    FMT_OTHER, FMT_BYTE, FMT_BIT, FMT_LIT8, FMT_LFSR, FMT_MOVFF,
    FMT_IDX, FMT_GOTO, FMT_CALL, FMT_BRA8, FMT_BRA11, FMT_RETURN, FMT_TBL
  } ofd_fmt_t;

  // Register byte offsets
  localparam logic [7:0] OFF_BANK = 8'h00;
  localparam logic [7:0] OFF_PTR0 = 8'h04;
  localparam logic [7:0] OFF_TABLE_POINTER = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam int NUM_PTR = 3;

  // Field positions and tags
  localparam int POS_A = 8;
  localparam int POS_D = 9;
  localparam int POS_S_CALL = 8;
  localparam int POS_S_RET = 0;
  localparam logic [3:0] SECOND_TAG = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [1:0] IDX_PTR = 2'h2;

  // Widths and reset values
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam int TABLE_POINTER_W = 21;
  localparam int FLAG_W = 5;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
  localparam logic [TABLE_POINTER_W-1:0] TABLE_POINTER_RST = 21'h000000;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;

  // Table pointer modes and literal widths
  localparam logic [1:0] TM_NONE = 2'h0;
  localparam logic [1:0] TM_POST_INC = 2'h1;
  localparam logic [1:0] TM_POST_DEC = 2'h2;
  localparam logic [1:0] TM_PRE_INC = 2'h3;
  localparam logic [1:0] LW_NONE = 2'h0;
  localparam logic [1:0] LW_8 = 2'h1;
  localparam logic [1:0] LW_12 = 2'h2;
  localparam logic [1:0] LW_20 = 2'h3;

  typedef struct packed {
    logic valid;
    ofd_fmt_t fmt;
    logic [15:0] word;
  } ofd_instr_t;

  typedef struct packed {
    logic [FLAG_W-1:0] mask;
    logic [FLAG_W-1:0] val;
  } ofd_flag_upd_t;

  typedef struct packed {
    logic valid;
    logic nop;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [7:0] bit_mask;
    logic dst_working_accumulator;
    logic dst_file;
    logic [1:0] ptr_sel;
    logic [19:0] literal;
    logic [1:0] lit_width;
    logic rel_branch;
    logic [TABLE_POINTER_W-1:0] branch_off;
    logic shadow_save;
    logic shadow_restore;
    logic tbl_op;
    logic [1:0] tbl_mode;
  } ofd_dec_t;
endpackage : ofd_pkg

// ==== ofd_decoder.sv ====
/*
 Operand field decoder with AHB-Lite register slave.
 Assumes instruction words and flag updates come from logic on hclk.
*/
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
// Functional notes
// - Access bit clear: address goes to access bank, bank register ignored.
// - Access bit set: bank comes from current bank register contents.
// - Three-bit bit index selects one bit 0..7 of the register.
// - Destination bit clear: result to accumulator, register unchanged.
// - Destination bit set: result written back to addressed register.
// - File field is 8-bit address or 2-bit pointer selector.
// - Move source uses full 12-bit address, no banking.
// - Move destination uses its own full 12-bit address.
// - Literal extracted as 8, 12 or 20 bits, as data or target.
// - Table ops apply none, post-inc, post-dec or pre-inc mode.
// - Branch field signed relative offset, or absolute for call/jump.
// - Fast bit clear: no shadow save or restore.
// - Fast bit set: call saves to shadows, return restores.
// - Table pointer is a 21-bit program memory address register.
// - Indexed source adds 7-bit offset to indirect pointer.
// - Indexed destination adds separate 7-bit offset to pointer.
// - Five ALU flags kept and updated per instruction result.
// - Second word has top nibble ones; alone it acts as no-op.
`timescale 1ns/1ps
module ofd_decoder (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ofd_pkg::ofd_instr_t instr,
  input wire ofd_pkg::ofd_flag_upd_t flag_upd,
  output ofd_pkg::ofd_dec_t dec,
  output logic [ofd_pkg::TABLE_POINTER_W-1:0] tbl_addr,
  output logic [ofd_pkg::FLAG_W-1:0] alu_flags
);
  logic [ofd_pkg::BANK_W-1:0] bank_select_reg;
  logic [ofd_pkg::ADDR_W-1:0] indirect_pointer_reg [ofd_pkg::NUM_PTR];
  logic [ofd_pkg::TABLE_POINTER_W-1:0] table_pointer_reg;
  logic [ofd_pkg::TABLE_POINTER_W-1:0] table_pointer_next;
  logic [ofd_pkg::TABLE_POINTER_W-1:0] tbl_addr_reg;
  logic [ofd_pkg::TABLE_POINTER_W-1:0] tbl_addr_next;
  logic [ofd_pkg::FLAG_W-1:0] alu_flags_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] bus_addr_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_mux;
  logic pend_valid_reg;
  ofd_pkg::ofd_fmt_t pend_fmt_reg;
  logic [15:0] pend_word_reg;
  ofd_pkg::ofd_dec_t dec_reg;
  ofd_pkg::ofd_dec_t dec_next;

  // Bus decode
  wire ahb_take = hsel && htrans[1] && hready;
  wire wr_bank = wr_pend_reg && bus_addr_reg == ofd_pkg::OFF_BANK;
  wire wr_tbl = wr_pend_reg && bus_addr_reg == ofd_pkg::OFF_TABLE_POINTER;
  assign hreadyout = !rd_pend_reg;
  assign hresp = 1'b0;
  assign hrdata = rd_data_reg;

  // Bus phase tracking; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
      rd_data_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= ahb_take && hwrite;
      rd_pend_reg <= ahb_take && !hwrite;
      if (ahb_take) begin
        bus_addr_reg <= haddr[7:0];
      end
      if (rd_pend_reg) begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (bus_addr_reg)
      ofd_pkg::OFF_BANK: rd_mux[ofd_pkg::BANK_W-1:0] = bank_select_reg;
      ofd_pkg::OFF_TABLE_POINTER: rd_mux[ofd_pkg::TABLE_POINTER_W-1:0] = table_pointer_reg;
      ofd_pkg::OFF_FLAGS: rd_mux[ofd_pkg::FLAG_W-1:0] = alu_flags_reg;
      ofd_pkg::OFF_STATUS: rd_mux[0] = pend_valid_reg;
      default: begin
        for (int i = 0; i < ofd_pkg::NUM_PTR; i++) begin
          if (bus_addr_reg == ofd_pkg::OFF_PTR0 + 8'(4 * i)) begin
            rd_mux[ofd_pkg::ADDR_W-1:0] = indirect_pointer_reg[i];
          end
        end
      end
    endcase
  end

  // Bank select register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_select_reg <= ofd_pkg::BANK_RST;
    end else if (wr_bank) begin
      bank_select_reg <= hwdata[ofd_pkg::BANK_W-1:0];
    end
  end

  // Indirect pointer registers, one word each
  generate
    for (genvar g = 0; g < ofd_pkg::NUM_PTR; g++) begin : g_ptr
      localparam logic [7:0] PTR_OFF = ofd_pkg::OFF_PTR0 + 8'(4 * g);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          indirect_pointer_reg[g] <= ofd_pkg::PTR_RST;
        end else if (wr_pend_reg && bus_addr_reg == PTR_OFF) begin
          indirect_pointer_reg[g] <= hwdata[ofd_pkg::ADDR_W-1:0];
        end
      end
    end
  endgenerate

  // Field extraction
  wire [15:0] w = instr.word;
  wire is_f_word = w[15:12] == ofd_pkg::SECOND_TAG;
  wire first_ok = instr.valid && !pend_valid_reg && !is_f_word;
  wire two_word = instr.fmt == ofd_pkg::FMT_LFSR ||
    instr.fmt == ofd_pkg::FMT_MOVFF || instr.fmt == ofd_pkg::FMT_IDX ||
    instr.fmt == ofd_pkg::FMT_GOTO || instr.fmt == ofd_pkg::FMT_CALL;
  wire start_pair = first_ok && two_word;
  wire [3:0] acc_bank = (w[7:0] >= ofd_pkg::ACCESS_SPLIT) ?
    ofd_pkg::ACCESS_HI_BANK : ofd_pkg::ACCESS_LO_BANK;
  wire [ofd_pkg::ADDR_W-1:0] fa_addr = w[ofd_pkg::POS_A] ?
    {bank_select_reg, w[7:0]} : {acc_bank, w[7:0]};
  wire [ofd_pkg::ADDR_W-1:0] idx_base =
    indirect_pointer_reg[ofd_pkg::IDX_PTR];
  wire tbl_go = first_ok && instr.fmt == ofd_pkg::FMT_TBL;

  // Combinational decode of the accepted word
  always_comb begin
    dec_next = '0;
    dec_next.valid = instr.valid && !start_pair;
    if (pend_valid_reg) begin
      case (pend_fmt_reg)
        ofd_pkg::FMT_MOVFF: begin
          dec_next.src_addr = pend_word_reg[11:0];
          dec_next.dst_addr = w[11:0];
          dec_next.dst_file = 1'b1;
        end
        ofd_pkg::FMT_LFSR: begin
          dec_next.ptr_sel = pend_word_reg[5:4];
          dec_next.literal = {8'h00, pend_word_reg[3:0], w[7:0]};
          dec_next.lit_width = ofd_pkg::LW_12;
        end
        ofd_pkg::FMT_IDX: begin
          dec_next.src_addr = idx_base + {5'h00, pend_word_reg[6:0]};
          dec_next.dst_addr = idx_base + {5'h00, w[6:0]};
          dec_next.dst_file = 1'b1;
        end
        ofd_pkg::FMT_GOTO, ofd_pkg::FMT_CALL: begin
          dec_next.literal = {w[11:0], pend_word_reg[7:0]};
          dec_next.lit_width = ofd_pkg::LW_20;
          dec_next.shadow_save = pend_fmt_reg == ofd_pkg::FMT_CALL &&
            pend_word_reg[ofd_pkg::POS_S_CALL];
        end
        default: dec_next.nop = 1'b1;
      endcase
    end else if (is_f_word) begin
      dec_next.nop = 1'b1;
    end else begin
      case (instr.fmt)
        ofd_pkg::FMT_BYTE: begin
          dec_next.src_addr = fa_addr;
          dec_next.dst_working_accumulator = !w[ofd_pkg::POS_D];
          dec_next.dst_file = w[ofd_pkg::POS_D];
          dec_next.dst_addr = w[ofd_pkg::POS_D] ? fa_addr : '0;
        end
        ofd_pkg::FMT_BIT: begin
          dec_next.src_addr = fa_addr;
          dec_next.bit_mask = 8'h01 << w[11:9];
        end
        ofd_pkg::FMT_LIT8: begin
          dec_next.literal = {12'h000, w[7:0]};
          dec_next.lit_width = ofd_pkg::LW_8;
        end
        ofd_pkg::FMT_BRA8: begin
          dec_next.rel_branch = 1'b1;
          dec_next.branch_off = {{13{w[7]}}, w[7:0]};
        end
        ofd_pkg::FMT_BRA11: begin
          dec_next.rel_branch = 1'b1;
          dec_next.branch_off = {{10{w[10]}}, w[10:0]};
        end
        ofd_pkg::FMT_RETURN: begin
          dec_next.shadow_restore = w[ofd_pkg::POS_S_RET];
        end
        ofd_pkg::FMT_TBL: begin
          dec_next.tbl_op = 1'b1;
          dec_next.tbl_mode = w[1:0];
        end
        default: dec_next.nop = 1'b0;
      endcase
    end
  end

  // Table pointer update; a software write wins over the mode step
  always_comb begin
    table_pointer_next = table_pointer_reg;
    tbl_addr_next = tbl_addr_reg;
    if (tbl_go) begin
      tbl_addr_next = table_pointer_reg;
      case (w[1:0])
        ofd_pkg::TM_POST_INC: table_pointer_next = table_pointer_reg + 21'h1;
        ofd_pkg::TM_POST_DEC: table_pointer_next = table_pointer_reg - 21'h1;
        ofd_pkg::TM_PRE_INC: begin
          table_pointer_next = table_pointer_reg + 21'h1;
          tbl_addr_next = table_pointer_reg + 21'h1;
        end
        default: table_pointer_next = table_pointer_reg;
      endcase
    end
    if (wr_tbl) begin
      table_pointer_next = hwdata[ofd_pkg::TABLE_POINTER_W-1:0];
    end
  end

  // Decode, pointer, flag and pairing state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_reg <= '0;
      table_pointer_reg <= ofd_pkg::TABLE_POINTER_RST;
      tbl_addr_reg <= ofd_pkg::TABLE_POINTER_RST;
      alu_flags_reg <= ofd_pkg::FLAGS_RST;
      pend_valid_reg <= 1'b0;
      pend_fmt_reg <= ofd_pkg::FMT_OTHER;
      pend_word_reg <= 16'h0000;
    end else begin
      dec_reg <= dec_next;
      table_pointer_reg <= table_pointer_next;
      tbl_addr_reg <= tbl_addr_next;
      alu_flags_reg <= (alu_flags_reg & ~flag_upd.mask) |
        (flag_upd.val & flag_upd.mask);
      if (instr.valid) begin
        pend_valid_reg <= start_pair;
      end
      if (start_pair) begin
        pend_fmt_reg <= instr.fmt;
        pend_word_reg <= w;
      end
    end
  end

  assign dec = dec_reg;
  assign tbl_addr = tbl_addr_reg;
  assign alu_flags = alu_flags_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_access_bank: assert property (
    first_ok && instr.fmt == ofd_pkg::FMT_BYTE && !w[ofd_pkg::POS_A]
    |=> dec.src_addr[7:0] == $past(w[7:0]) &&
        dec.src_addr[11:8] == ($past(w[7]) ? 4'hF : 4'h0))
    else $error("access bank address wrong");
  a_banked_addr: assert property (
    first_ok && instr.fmt == ofd_pkg::FMT_BIT && w[ofd_pkg::POS_A]
    |=> dec.src_addr == {$past(bank_select_reg), $past(w[7:0])})
    else $error("banked address wrong");
  a_bit_mask: assert property (
    first_ok && instr.fmt == ofd_pkg::FMT_BIT
    |=> $onehot(dec.bit_mask) && dec.bit_mask[$past(w[11:9])])
    else $error("bit mask wrong");
  a_dest_sel: assert property (
    first_ok && instr.fmt == ofd_pkg::FMT_BYTE
    |=> dec.dst_file == !dec.dst_working_accumulator && dec.dst_file == $past(w[9]))
    else $error("destination select wrong");
  a_move_addr: assert property (
    pend_valid_reg && instr.valid && pend_fmt_reg == ofd_pkg::FMT_MOVFF
    |=> dec.valid && dec.src_addr == $past(pend_word_reg[11:0]) &&
        dec.dst_addr == $past(w[11:0]))
    else $error("move addresses wrong");
  a_lit_width: assert property (
    first_ok && instr.fmt == ofd_pkg::FMT_LIT8
    |=> dec.lit_width == ofd_pkg::LW_8 && dec.literal == {12'h000,
        $past(w[7:0])})
    else $error("literal wrong");
  a_tbl_post_inc: assert property (
    tbl_go && w[1:0] == ofd_pkg::TM_POST_INC && !wr_tbl
    |=> tbl_addr == $past(table_pointer_reg) &&
        table_pointer_reg == $past(table_pointer_reg) + 21'h1)
    else $error("post increment wrong");
  a_tbl_pre_inc: assert property (
    tbl_go && w[1:0] == ofd_pkg::TM_PRE_INC && !wr_tbl
    |=> tbl_addr == table_pointer_reg &&
        tbl_addr == $past(table_pointer_reg) + 21'h1)
    else $error("pre increment wrong");
  a_shadow_ret: assert property (
    first_ok && instr.fmt == ofd_pkg::FMT_RETURN
    |=> dec.shadow_restore == $past(w[0]) && !dec.shadow_save)
    else $error("shadow restore wrong");
  a_second_nop: assert property (
    instr.valid && !pend_valid_reg && is_f_word
    |=> dec.valid && dec.nop && !dec.dst_file && !dec.tbl_op)
    else $error("lone second word not a no-op");
  a_idx_src: assert property (
    pend_valid_reg && instr.valid && pend_fmt_reg == ofd_pkg::FMT_IDX
    |=> dec.src_addr == $past(idx_base) + {5'h00, $past(pend_word_reg[6:0])})
    else $error("indexed source wrong");
  a_flags_hold: assert property (
    flag_upd.mask == 5'h00 |=> $stable(alu_flags))
    else $error("flags changed without update");

  c_move_pair: cover property (start_pair ##[1:2] instr.valid ##1 dec.valid);
  c_lone_nop: cover property (instr.valid && !pend_valid_reg && is_f_word);
  c_tbl_dec: cover property (tbl_go && w[1:0] == ofd_pkg::TM_POST_DEC);
endmodule : ofd_decoder

// ==== ofd_fetch_model.sv ====
/*
 Fetch-side model: hands queued instruction words to the decoder.
 Assumes the bench fills the queue through push and drives slow.
*/
`timescale 1ns/1ps
module ofd_fetch_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  output ofd_pkg::ofd_instr_t instr
);
  ofd_pkg::ofd_instr_t q[$];
  logic gap_reg;

  task automatic push(input ofd_pkg::ofd_fmt_t f, input logic [15:0] w);
    q.push_back(ofd_pkg::ofd_instr_t'({1'b1, f, w}));
  endtask : push

  // One word a cycle, every other cycle when slow; idle word toggles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr <= '0;
      gap_reg <= 1'b0;
    end else if (q.size() != 0 && !(slow && gap_reg)) begin
      instr <= q.pop_front();
      gap_reg <= 1'b1;
    end else begin
      instr.valid <= 1'b0;
      instr.word <= ~instr.word;
      gap_reg <= 1'b0;
    end
  end
endmodule : ofd_fetch_model

// ==== opcode_field_decoder_tb.sv ====
/*
 Self-checking bench for the operand field decoder.
 Assumes a single AHB-Lite master and the fetch model as word source.
*/
`timescale 1ns/1ps
module opcode_field_decoder_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, ok;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rnd, rd;
  logic [7:0] f;
  ofd_pkg::ofd_instr_t instr;
  ofd_pkg::ofd_flag_upd_t flag_upd;
  ofd_pkg::ofd_dec_t dec;
  logic [20:0] tbl_addr;
  logic [4:0] alu_flags;
  int miscompares, total_checks, bank, ptr2, tp, flg, i, j, e;

  ofd_decoder u_ofd_decoder (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .instr(instr), .flag_upd(flag_upd), .dec(dec),
    .tbl_addr(tbl_addr), .alu_flags(alu_flags));
  ofd_fetch_model u_ofd_fetch_model (.hclk(hclk), .hresetn(hresetn),
    .slow(slow), .instr(instr));

  // Clock of 5 ns
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task end_sim;
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Holds the current phase until hready is seen high at an edge
  task wait_rdy;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask : wait_rdy

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    chk(hresp, 32'h0);
  endtask : bus

  // Queues one or two words, then waits for the decode pulse
  task send(input ofd_pkg::ofd_fmt_t ft, input logic [15:0] w1,
    input logic [11:0] w2, input logic two);
    u_ofd_fetch_model.push(ft, w1);
    if (two)
      u_ofd_fetch_model.push(ofd_pkg::FMT_OTHER, {4'hF, w2});
    i = 0;
    do begin
      @(negedge hclk);
      i++;
    end while (dec.valid !== 1'b1 && i < 20);
    chk(dec.valid, 32'h1);
  endtask : send

  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, slow} = 3'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    flag_upd = '0;
    rnd = 32'hF21D;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(dec.valid, 32'h0);
    chk(tbl_addr, 32'h0);
    bus(1'b0, ofd_pkg::OFF_BANK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    for (j = 0; j < 16; j++) begin
      rnd = nxt(rnd);
      bank = rnd[11:8];
      bus(1'b1, ofd_pkg::OFF_BANK, {28'h0, rnd[11:8]});
      f = (j < 8) ? (j[2] ? 8'h80 : 8'h7F) : rnd[7:0];
      send(ofd_pkg::FMT_BYTE, {6'h0, j[1], j[0], f}, 12'h0, 1'b0);
      e = j[0] ? bank * 256 + f : (f >= ofd_pkg::ACCESS_SPLIT) * 'hF00 + f;
      chk(dec.src_addr, e);
      chk(dec.dst_file, j[1]);
      chk(dec.dst_working_accumulator, !j[1]);
      chk(dec.dst_addr, j[1] ? e : 0);
    end
    for (j = 0; j < 8; j++) begin
      send(ofd_pkg::FMT_BIT, {4'h9, j[2:0], j[0], 8'h12}, 12'h0, 1'b0);
      chk(dec.bit_mask, 1 << j);
      chk(dec.src_addr, j[0] ? bank * 256 + 'h12 : 'h12);
    end
    slow <= 1'b1;
    send(ofd_pkg::FMT_MOVFF, 16'hC000, 12'hFFF, 1'b1);
    chk({dec.src_addr, dec.dst_addr}, 24'h000FFF);
    send(ofd_pkg::FMT_MOVFF, 16'hCFFF, 12'h000, 1'b1);
    chk({dec.src_addr, dec.dst_addr, dec.dst_file}, 25'h1FFE001);
    send(ofd_pkg::FMT_LIT8, {8'h0E, rnd[7:0]}, 12'h0, 1'b0);
    chk({dec.nop, dec.lit_width, dec.literal}, {3'h1, 12'h0, rnd[7:0]});
    send(ofd_pkg::FMT_LFSR, 16'hEE2A, 12'h05C, 1'b1);
    chk({dec.ptr_sel, dec.lit_width, dec.literal}, 24'hA00A5C);
    send(ofd_pkg::FMT_GOTO, 16'hEF34, 12'hABC, 1'b1);
    chk({dec.rel_branch, dec.lit_width, dec.literal}, 23'h3ABC34);
    send(ofd_pkg::FMT_BRA8, 16'hE080, 12'h0, 1'b0);
    chk({dec.rel_branch, dec.branch_off}, 22'h3FFF80);
    send(ofd_pkg::FMT_BRA8, 16'hE07F, 12'h0, 1'b0);
    chk({dec.rel_branch, dec.branch_off}, 22'h20007F);
    send(ofd_pkg::FMT_BRA11, 16'hD400, 12'h0, 1'b0);
    chk({dec.rel_branch, dec.branch_off}, 22'h3FFC00);
    for (j = 0; j < 2; j++) begin
      send(ofd_pkg::FMT_CALL, {7'h76, j[0], 8'h00}, 12'h0, 1'b1);
      chk({dec.shadow_save, dec.shadow_restore}, j * 2);
      send(ofd_pkg::FMT_RETURN, {15'h0009, j[0]}, 12'h0, 1'b0);
      chk({dec.shadow_save, dec.shadow_restore}, j);
    end
    tp = 'h1FFFFF;
    bus(1'b1, ofd_pkg::OFF_TABLE_POINTER, 32'h001FFFFF);
    for (j = 0; j < 4; j++) begin
      send(ofd_pkg::FMT_TBL, {14'h0002, j[1:0]}, 12'h0, 1'b0);
      e = (j == 3) ? (tp + 1) & 'h1FFFFF : tp;
      tp = (j == 2) ? tp - 1 : (j[0] ? tp + 1 : tp);
      tp = tp & 'h1FFFFF;
      chk({dec.tbl_op, dec.tbl_mode}, 4 + j);
      chk(tbl_addr, e);
    end
    bus(1'b0, ofd_pkg::OFF_TABLE_POINTER, 32'h0);
    chk(rd, tp);
    rnd = nxt(rnd);
    ptr2 = rnd[10:0];
    bus(1'b1, ofd_pkg::OFF_PTR0 + 8'h08, {21'h0, rnd[10:0]});
    send(ofd_pkg::FMT_IDX, 16'hE87F, 12'h005, 1'b1);
    chk(dec.src_addr, ptr2 + 'h7F);
    chk(dec.dst_addr, ptr2 + 'h05);
    send(ofd_pkg::FMT_OTHER, 16'hF123, 12'h0, 1'b0);
    chk(dec.nop, 32'h1);
    @(posedge hclk);
    flag_upd <= {5'h1F, rnd[4:0]};
    @(posedge hclk);
    flag_upd <= {rnd[9:5], rnd[14:10]};
    @(posedge hclk);
    flag_upd <= '0;
    flg = (rnd[4:0] & ~rnd[9:5]) | (rnd[14:10] & rnd[9:5]);
    @(negedge hclk);
    chk(alu_flags, flg);
    bus(1'b0, ofd_pkg::OFF_FLAGS, 32'h0);
    chk(rd, flg);
    // Mid-run reset returns table address, flags and bank to their reset values
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({tbl_addr, alu_flags, dec.valid}, 32'h0);
    bus(1'b0, ofd_pkg::OFF_BANK, 32'h0);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule : opcode_field_decoder_tb
